// ===== rtl/v86_pkg.sv
// shared constants, types and register map for the compatibility-mode dispatch unit
package v86_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL   = 8'h00;	// bit 0 mode extension enable
	localparam logic [7:0] OFF_FLAGS  = 8'h04;	// live flags register
	localparam logic [7:0] OFF_CPL    = 8'h08;	// current privilege level
	localparam logic [7:0] OFF_STATUS = 8'h0C;	// state, last method
	localparam logic [7:0] OFF_ERR    = 8'h10;	// last fault error code
	localparam logic [7:0] OFF_SEG_LO = 8'h14;	// data selectors 0 and 1
	localparam logic [7:0] OFF_SEG_HI = 8'h18;	// data selectors 2 and 3
	localparam logic [7:0] OFF_BITMAP = 8'h20;	// eight words, 0x20..0x3C

	// ----------------------------------------------------------------
	// flags layout and reset values
	// ----------------------------------------------------------------
	localparam int unsigned FL_TF   = 8;
	localparam int unsigned FL_IF   = 9;
	localparam int unsigned FL_IO_PRIVILEGE_LEVEL = 12;	// two bits, 13:12
	localparam int unsigned FL_NT   = 14;
	localparam int unsigned FL_VM   = 17;
	localparam int unsigned FL_VIF  = 19;
	localparam int unsigned FL_VIP  = 20;
	localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
	localparam logic [1:0]  CPL_RESET   = 2'h0;
	localparam logic [1:0]  PL_USER     = 2'h3;
	localparam logic [1:0]  PL_KERNEL   = 2'h0;

	// ----------------------------------------------------------------
	// counts
	// ----------------------------------------------------------------
	localparam logic [3:0] GATE_PUSHES  = 4'h9;	// gs fs ds es ss esp flags cs eip
	localparam logic [3:0] REDIR_PUSHES = 4'h3;	// flags16 cs ip16
	localparam logic [3:0] TASK_STEPS   = 4'h3;	// store flags, link, load
	localparam logic [7:0] FIRST_MASKABLE = 8'h20;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {GATE_TASK, GATE_TRAP, GATE_INTR, GATE_BAD} gate_kind_t;
	typedef enum logic [1:0] {M_GATE, M_FAULT, M_REDIR} method_t;
	typedef enum logic [1:0] {WR_PUSH0, WR_PUSH_CUR, WR_TSS_FLAGS, WR_TSS_LINK} wr_kind_t;

	typedef struct packed {
		gate_kind_t  kind;
		logic        conforming;
		logic [1:0]  dpl;
		logic [15:0] code_sel;
		logic [31:0] entry;
		logic [31:0] new_flags;	// flags image of the called task
	} desc_rsp_t;

	typedef struct packed {
		logic [31:0] eip;
		logic [15:0] cs;
		logic [31:0] esp;
		logic [15:0] ss;
		logic [15:0] tss_sel;
	} core_state_t;

	typedef struct packed {
		wr_kind_t    kind;
		logic [31:0] data;
	} mem_wr_t;

endpackage

// ===== rtl/v86_method_decode.sv
// combinational choice of the handling method for one vector
`timescale 1ns/10ps
`default_nettype none
module v86_method_decode
(
	input  wire logic                 virtual_mode_ext_enable,
	input  wire logic [1:0]           io_privilege_level,
	input  wire logic                 virtual_int_flag,
	input  wire logic [7:0]           vector,
	input  wire logic [7:0][31:0]     bitmap,
	output v86_pkg::method_t          method,
	output logic                      vif_call
);
	logic redir_bit;
	logic iopl3;

	// bitmap bit looked up only with the extension on
	always_comb
	begin
		iopl3 = (io_privilege_level == v86_pkg::PL_USER);
		redir_bit = virtual_mode_ext_enable ? bitmap[vector[7:5]][vector[4:0]] : 1'b1;
		vif_call = 1'b0;
		if (!virtual_mode_ext_enable)
			method = iopl3 ? v86_pkg::M_GATE : v86_pkg::M_FAULT;
		else if (redir_bit)
			method = iopl3 ? v86_pkg::M_GATE : v86_pkg::M_FAULT;
		else if (!iopl3 && virtual_int_flag && vector >= v86_pkg::FIRST_MASKABLE)
		begin
			method = v86_pkg::M_GATE;	// masked virtual interrupt goes to handler
			vif_call = 1'b1;
		end
		else
			method = v86_pkg::M_REDIR;
	end
endmodule
`default_nettype wire

// ===== rtl/v86_frame_mux.sv
// selects the word pushed at each step of a state frame
`timescale 1ns/10ps
`default_nettype none
module v86_frame_mux
(
	input  wire logic [3:0]           idx,
	input  wire logic                 redir,
	input  wire logic                 vif_call,
	input  wire logic [31:0]          flags,
	input  wire v86_pkg::core_state_t core,
	input  wire logic [3:0][15:0]     segs,
	output logic [31:0]               word
);
	logic [31:0] img;

	// gate frame: gs fs ds es ss esp flags cs eip; redirect: flags16 cs ip16
	always_comb
	begin
		img = flags;
		if (vif_call)
		begin
			img[v86_pkg::FL_IO_PRIVILEGE_LEVEL +: 2] = v86_pkg::PL_USER;
			img[v86_pkg::FL_IF] = flags[v86_pkg::FL_VIF];
		end
		word = 32'h0000_0000;
		if (redir)
		begin
			unique case (idx)
				4'h0: word = {16'h0000, flags[15:15], 1'b0, 2'h0, flags[11:0]};
				4'h1: word = {16'h0000, core.cs};
				default: word = {16'h0000, core.eip[15:0]};
			endcase
		end
		else
		begin
			unique case (idx)
				4'h0: word = {16'h0000, segs[3]};
				4'h1: word = {16'h0000, segs[2]};
				4'h2: word = {16'h0000, segs[1]};
				4'h3: word = {16'h0000, segs[0]};
				4'h4: word = {16'h0000, core.ss};
				4'h5: word = core.esp;
				4'h6: word = img;
				4'h7: word = {16'h0000, core.cs};
				default: word = core.eip;
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== rtl/v86_interrupt_dispatch.sv
// compatibility-mode interrupt and exception dispatch unit
// Operation
// - extension off and I/O level 3: dispatch through the protected descriptor table.
// - gate dispatch switches to level 0 first; the v86 mode flag stays set during the pushes.
// - gate dispatch pushes ip, cs, flags, sp, ss and four data selectors.
// - the four data selectors are zeroed after being saved.
// - finally the v86 mode flag is cleared and the handler fetch starts.
// - conforming or non-zero-level target raises a fault coded with its selector.
// - stack return reloads flags and selectors; set mode image resumes compatibility mode.
// - a return changes the v86 mode flag only at privilege level 0.
// - zero data selectors never trap on a return.
// - task gate stores current flags, mode flag set, into the outgoing segment.
// - task gate writes the outgoing segment selector into the back-link.
// - flags load from the new image, nested flag set, handler task begins.
// - extension off and I/O level below 3: every event becomes a fault.
// - filtered fault mode: bit 1 faults, bit 0 redirects, or goes to the handler when the virtual flag is set and the vector is 0x20 or above.
// - extension on, level 3, bit 1: dispatch as through the protected table.
// - direct redirect pushes masked flags, cs, ip; clears enable and trap.
// - redirection bit comes from a 32-byte bitmap, bit 0 for vector 0.
// - with virtual handling, disable and enable act on the virtual flag; enable with a virtual interrupt pending faults instead.
`timescale 1ns/10ps
`default_nettype none
module v86_interrupt_dispatch
(
	input  wire logic                 sys_clk,
	input  wire logic                 reset,
	input  wire logic                 clk_en,
	input  wire logic [7:0]           reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic [31:0]               reg_rdata,
	input  wire logic                 evt_req,
	input  wire logic [7:0]           evt_vec,
	output logic                      evt_ready,
	input  wire v86_pkg::core_state_t core,
	output logic                      desc_req,
	output logic [7:0]                desc_vec,
	input  wire logic                 desc_ack,
	input  wire v86_pkg::desc_rsp_t   desc_rsp,
	output logic                      mem_wr_valid,
	output v86_pkg::mem_wr_t          mem_wr,
	input  wire logic                 interrupt_return_instr_req,
	input  wire logic [31:0]          interrupt_return_instr_flags,
	input  wire logic [3:0][15:0]     interrupt_return_instr_segs,
	input  wire logic                 int_disable_instr,
	input  wire logic                 int_enable_instr,
	output logic                      fetch_start,
	output logic                      fetch_ivt,
	output logic [31:0]               fetch_addr,
	output logic                      general_protection_fault,
	output logic [15:0]               gp_code,
	output logic                      v86_active
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {ST_IDLE, ST_DESC, ST_PUSH, ST_ENTER, ST_TASK, ST_REDIR} state_t;

	state_t            st_q, st_d;
	logic [3:0]        idx_q, idx_d;
	logic [7:0]        vec_q, vec_d;
	logic              vifc_q, vifc_d;
	logic              intr_q, intr_d;
	logic [31:0]       entry_q, entry_d;
	logic [31:0]       flags_q, flags_d;
	logic [1:0]        cpl_q, cpl_d;
	logic              vme_q, vme_d;
	logic [3:0][15:0]  segs_q, segs_d;
	logic [7:0][31:0]  bitmap_q, bitmap_d;
	logic [15:0]       err_q, err_d;
	v86_pkg::method_t  meth_q, meth_d;
	logic [31:0]       rdata_q, rdata_d;
	logic              wrv_q, wrv_d;
	v86_pkg::mem_wr_t  wr_q, wr_d;
	logic              fs_q, fs_d, fi_q, fi_d, gp_q, gp_d;
	logic [31:0]       fa_q, fa_d;
	logic [15:0]       gc_q, gc_d;

	v86_pkg::method_t  method;
	logic              vif_call;
	logic [31:0]       push_word;
	logic              evt_take, interrupt_return_instr_take, virt_if;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	v86_method_decode u_decode
	(
		.virtual_mode_ext_enable      (vme_q),
		.io_privilege_level     (flags_q[v86_pkg::FL_IO_PRIVILEGE_LEVEL +: 2]),
		.virtual_int_flag      (flags_q[v86_pkg::FL_VIF]),
		.vector   (evt_vec),
		.bitmap   (bitmap_q),
		.method   (method),
		.vif_call (vif_call)
	);

	v86_frame_mux u_frame
	(
		.idx      (idx_q),
		.redir    (st_q == ST_REDIR),
		.vif_call (vifc_q),
		.flags    (flags_q),
		.core     (core),
		.segs     (segs_q),
		.word     (push_word)
	);

	// handshake outputs
	assign evt_ready = (st_q == ST_IDLE);
	assign evt_take  = clk_en && evt_req && evt_ready && flags_q[v86_pkg::FL_VM];
	assign interrupt_return_instr_take = clk_en && interrupt_return_instr_req && evt_ready && !evt_req;
	assign desc_req  = (st_q == ST_DESC);
	assign desc_vec  = vec_q;
	assign virt_if   = vme_q && flags_q[v86_pkg::FL_VM]
		&& (flags_q[v86_pkg::FL_IO_PRIVILEGE_LEVEL +: 2] != v86_pkg::PL_USER);

	// ----------------------------------------------------------------
	// dispatch sequencer and register file
	// ----------------------------------------------------------------
	always_comb
	begin
		st_d = st_q; idx_d = idx_q; vec_d = vec_q; vifc_d = vifc_q;
		intr_d = intr_q; entry_d = entry_q; flags_d = flags_q; cpl_d = cpl_q;
		vme_d = vme_q; segs_d = segs_q; bitmap_d = bitmap_q; err_d = err_q;
		meth_d = meth_q; rdata_d = 32'h0000_0000;
		wrv_d = 1'b0; wr_d = wr_q; fs_d = 1'b0; fi_d = 1'b0; fa_d = fa_q;
		gp_d = 1'b0; gc_d = gc_q;
		unique case (st_q)
			ST_IDLE:
			begin
				if (evt_take)
				begin
					vec_d = evt_vec;
					meth_d = method;
					vifc_d = vif_call;
					idx_d = 4'h0;
					unique case (method)
						v86_pkg::M_GATE: st_d = ST_DESC;
						v86_pkg::M_FAULT:
						begin
							gp_d = 1'b1;
							gc_d = 16'h0000;
							err_d = 16'h0000;
						end
						default: st_d = ST_REDIR;
					endcase
				end
				else if (interrupt_return_instr_take)
				begin
					// no check on zero selectors
					segs_d = interrupt_return_instr_segs;
					flags_d = interrupt_return_instr_flags;
					if (cpl_q != v86_pkg::PL_KERNEL)
						flags_d[v86_pkg::FL_VM] = flags_q[v86_pkg::FL_VM];
					if (flags_d[v86_pkg::FL_VM])
						cpl_d = v86_pkg::PL_USER;
				end
				else if (clk_en && int_disable_instr)
				begin
					if (virt_if)
						flags_d[v86_pkg::FL_VIF] = 1'b0;
					else
						flags_d[v86_pkg::FL_IF] = 1'b0;
				end
				else if (clk_en && int_enable_instr)
				begin
					if (virt_if && flags_q[v86_pkg::FL_VIP])
						gp_d = 1'b1;	// pending virtual interrupt
					else if (virt_if)
						flags_d[v86_pkg::FL_VIF] = 1'b1;
					else
						flags_d[v86_pkg::FL_IF] = 1'b1;
				end
			end
			ST_DESC:
			begin
				if (desc_ack)
				begin
					entry_d = desc_rsp.entry;
					intr_d = (desc_rsp.kind == v86_pkg::GATE_INTR);
					unique case (desc_rsp.kind)
						v86_pkg::GATE_TASK: st_d = ST_TASK;
						v86_pkg::GATE_BAD:
						begin
							gp_d = 1'b1;
							gc_d = {5'h00, vec_q, 3'h2};	// descriptor-table error code
							err_d = {5'h00, vec_q, 3'h2};
							st_d = ST_IDLE;
						end
						default:
						begin
							if (desc_rsp.conforming || desc_rsp.dpl != v86_pkg::PL_KERNEL)
							begin
								gp_d = 1'b1;
								gc_d = desc_rsp.code_sel;
								err_d = desc_rsp.code_sel;
								st_d = ST_IDLE;
							end
							else
							begin
								cpl_d = v86_pkg::PL_KERNEL;
								st_d = ST_PUSH;
							end
						end
					endcase
				end
			end
			ST_PUSH:
			begin
				wrv_d = 1'b1;
				wr_d.kind = v86_pkg::WR_PUSH0;
				wr_d.data = push_word;
				idx_d = idx_q + 4'h1;
				if (idx_q == v86_pkg::GATE_PUSHES - 4'h1)
				begin
					segs_d = '0;
					st_d = ST_ENTER;
				end
			end
			ST_ENTER:
			begin
				flags_d[v86_pkg::FL_VM] = 1'b0;
				flags_d[v86_pkg::FL_TF] = 1'b0;
				if (intr_q)
					flags_d[v86_pkg::FL_IF] = 1'b0;
				fs_d = 1'b1;
				fa_d = entry_q;
				st_d = ST_IDLE;
			end
			ST_TASK:
			begin
				idx_d = idx_q + 4'h1;
				if (idx_q == 4'h0)
				begin
					wrv_d = 1'b1;
					wr_d.kind = v86_pkg::WR_TSS_FLAGS;
					wr_d.data = flags_q | (32'h1 << v86_pkg::FL_VM);
				end
				else if (idx_q == 4'h1)
				begin
					wrv_d = 1'b1;
					wr_d.kind = v86_pkg::WR_TSS_LINK;
					wr_d.data = {16'h0000, core.tss_sel};
				end
				else
				begin
					flags_d = desc_rsp.new_flags;
					flags_d[v86_pkg::FL_VM] = 1'b0;
					flags_d[v86_pkg::FL_NT] = 1'b1;
					cpl_d = v86_pkg::PL_KERNEL;
					fs_d = 1'b1;
					fa_d = entry_q;
					st_d = ST_IDLE;
				end
			end
			ST_REDIR:
			begin
				wrv_d = 1'b1;
				wr_d.kind = v86_pkg::WR_PUSH_CUR;
				wr_d.data = push_word;
				idx_d = idx_q + 4'h1;
				if (idx_q == v86_pkg::REDIR_PUSHES - 4'h1)
				begin
					flags_d[v86_pkg::FL_IF] = 1'b0;
					flags_d[v86_pkg::FL_TF] = 1'b0;
					fs_d = 1'b1;
					fi_d = 1'b1;
					fa_d = {22'h000000, vec_q, 2'h0};
					st_d = ST_IDLE;
				end
			end
			default: st_d = ST_IDLE;
		endcase
		// register port
		if (reg_wr)
		begin
			unique case (reg_addr)
				v86_pkg::OFF_CTRL:   vme_d = reg_wdata[0];
				v86_pkg::OFF_FLAGS:  flags_d = reg_wdata;
				v86_pkg::OFF_CPL:    cpl_d = reg_wdata[1:0];
				v86_pkg::OFF_SEG_LO: segs_d[1:0] = reg_wdata;
				v86_pkg::OFF_SEG_HI: segs_d[3:2] = reg_wdata;
				default:
				begin
					if (reg_addr[7:5] == v86_pkg::OFF_BITMAP[7:5] && reg_addr[1:0] == 2'h0)
						bitmap_d[reg_addr[4:2]] = reg_wdata;
				end
			endcase
		end
		if (reg_rd)
		begin
			unique case (reg_addr)
				v86_pkg::OFF_CTRL:   rdata_d = {31'h0, vme_q};
				v86_pkg::OFF_FLAGS:  rdata_d = flags_q;
				v86_pkg::OFF_CPL:    rdata_d = {30'h0, cpl_q};
				v86_pkg::OFF_STATUS: rdata_d = {24'h0, 1'b0, meth_q, 2'h0, st_q};
				v86_pkg::OFF_ERR:    rdata_d = {16'h0000, err_q};
				v86_pkg::OFF_SEG_LO: rdata_d = segs_q[1:0];
				v86_pkg::OFF_SEG_HI: rdata_d = segs_q[3:2];
				default:
				begin
					if (reg_addr[7:5] == v86_pkg::OFF_BITMAP[7:5] && reg_addr[1:0] == 2'h0)
						rdata_d = bitmap_q[reg_addr[4:2]];
				end
			endcase
		end
	end

	// registers, frozen while the clock enable is low
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			st_q <= ST_IDLE; idx_q <= 4'h0; vec_q <= 8'h00; vifc_q <= 1'b0;
			intr_q <= 1'b0; entry_q <= 32'h0000_0000; flags_q <= v86_pkg::FLAGS_RESET;
			cpl_q <= v86_pkg::CPL_RESET; vme_q <= 1'b0; segs_q <= '0; bitmap_q <= '0;
			err_q <= 16'h0000; meth_q <= v86_pkg::M_GATE; rdata_q <= 32'h0000_0000;
			wrv_q <= 1'b0; wr_q <= '0; fs_q <= 1'b0; fi_q <= 1'b0;
			fa_q <= 32'h0000_0000; gp_q <= 1'b0; gc_q <= 16'h0000;
		end
		else if (clk_en)
		begin
			st_q <= st_d; idx_q <= idx_d; vec_q <= vec_d; vifc_q <= vifc_d;
			intr_q <= intr_d; entry_q <= entry_d; flags_q <= flags_d;
			cpl_q <= cpl_d; vme_q <= vme_d; segs_q <= segs_d; bitmap_q <= bitmap_d;
			err_q <= err_d; meth_q <= meth_d; rdata_q <= rdata_d;
			wrv_q <= wrv_d; wr_q <= wr_d; fs_q <= fs_d; fi_q <= fi_d;
			fa_q <= fa_d; gp_q <= gp_d; gc_q <= gc_d;
		end
	end

	assign reg_rdata    = rdata_q;
	assign mem_wr_valid = wrv_q;
	assign mem_wr       = wr_q;
	assign fetch_start  = fs_q;
	assign fetch_ivt    = fi_q;
	assign fetch_addr   = fa_q;
	assign general_protection_fault = gp_q;
	assign gp_code      = gc_q;
	assign v86_active   = flags_q[v86_pkg::FL_VM];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset || !clk_en);

	a_fault_method2: assert property (evt_take && !vme_q
		&& flags_q[v86_pkg::FL_IO_PRIVILEGE_LEVEL +: 2] != v86_pkg::PL_USER |=> general_protection_fault)
		else $error("method 2 event did not fault");
	a_bitmap_fault: assert property (evt_take && vme_q && bitmap_q[evt_vec[7:5]][evt_vec[4:0]]
		&& flags_q[v86_pkg::FL_IO_PRIVILEGE_LEVEL +: 2] != v86_pkg::PL_USER |=> general_protection_fault)
		else $error("filtered vector did not fault");
	a_gate_frame: assert property ($rose(st_q == ST_PUSH) |-> (st_q == ST_PUSH)[*8]
		##1 st_q == ST_PUSH ##1 st_q == ST_ENTER
		##1 fetch_start && !v86_active && cpl_q == v86_pkg::PL_KERNEL)
		else $error("gate frame sequence wrong");
	a_segs_zero: assert property (st_q == ST_ENTER |-> segs_q == '0)
		else $error("data selectors not zeroed");
	a_conf_fault: assert property (st_q == ST_DESC && desc_ack
		&& desc_rsp.kind == v86_pkg::GATE_TRAP && desc_rsp.conforming
		|=> general_protection_fault && gp_code == $past(desc_rsp.code_sel) && st_q == ST_IDLE)
		else $error("conforming target not faulted");
	a_vm_keep: assert property (interrupt_return_instr_take && cpl_q != v86_pkg::PL_KERNEL
		|=> v86_active == $past(v86_active))
		else $error("mode flag changed outside level 0");
	a_tss_flags: assert property (st_q == ST_TASK && idx_q == 4'h0 |=> mem_wr_valid
		&& mem_wr.kind == v86_pkg::WR_TSS_FLAGS && mem_wr.data[v86_pkg::FL_VM]
		##1 mem_wr.kind == v86_pkg::WR_TSS_LINK)
		else $error("task switch store order wrong");
	a_task_nt: assert property (st_q == ST_TASK && idx_q == 4'h2
		|=> flags_q[v86_pkg::FL_NT] && !v86_active && fetch_start)
		else $error("task entry flags wrong");
	a_redir_flags: assert property (st_q == ST_REDIR && idx_q == 4'h0 |=> mem_wr_valid
		&& mem_wr.data[v86_pkg::FL_NT] == 1'b0 && mem_wr.data[13:12] == 2'h0
		##2 fetch_ivt && fetch_addr == {22'h0, vec_q, 2'h0} && !flags_q[v86_pkg::FL_IF])
		else $error("redirect frame wrong");
	a_cli_virtual: assert property (evt_ready && !evt_req && !interrupt_return_instr_req && int_disable_instr
		&& virt_if |=> !flags_q[v86_pkg::FL_VIF] && flags_q[v86_pkg::FL_IF] == $past(flags_q[9]))
		else $error("disable touched the real flag");

	c_gate: cover property (st_q == ST_ENTER);
	c_task: cover property (st_q == ST_TASK && idx_q == 4'h2);
	c_redir: cover property (fetch_ivt);
	c_fault: cover property (general_protection_fault);
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// self-checking bench for the compatibility-mode dispatch unit
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic	sys_clk, reset, clk_en, reg_wr, reg_rd, evt_req, desc_ack, evt_ready, desc_req;
	logic	mem_wr_valid, interrupt_return_instr_req, fetch_start, fetch_ivt, int_disable_instr, int_enable_instr;
	logic	general_protection_fault, v86_active;
	logic [7:0]	reg_addr, evt_vec, desc_vec;
	logic [15:0]	gp_code;
	logic [31:0]	reg_wdata, reg_rdata, interrupt_return_instr_flags, fetch_addr, rv;
	logic [3:0][15:0]	interrupt_return_instr_segs;
	v86_pkg::core_state_t	core;
	v86_pkg::desc_rsp_t	desc_rsp;
	v86_pkg::mem_wr_t	mem_wr;
	logic [33:0]	q_wr[$], q_fe[$], q_gp[$], e;
	int	errors = 0, compares = 0, cyc = 0, tn = 0;

	// --------
	// unit under test
	// --------
	v86_interrupt_dispatch v86_interrupt_dispatch_i
	(
		.sys_clk, .reset, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.evt_req, .evt_vec, .evt_ready, .core, .desc_req, .desc_vec, .desc_ack, .desc_rsp,
		.mem_wr_valid, .mem_wr, .interrupt_return_instr_req, .interrupt_return_instr_flags, .interrupt_return_instr_segs, .int_disable_instr,
		.int_enable_instr, .fetch_start, .fetch_ivt, .fetch_addr, .general_protection_fault,
		.gp_code, .v86_active
	);

	// clock and one-cycle descriptor answer
	always #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) desc_ack <= desc_req & ~desc_ack;

	// --------
	// helpers
	// --------
	task automatic end_of_test();
		$display("counts: %0d compares, %0d errors", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [33:0] s, input logic [33:0] x);
		compares++;
		if (s !== x || $isunknown(x))
		begin
			errors++;
			$display("Error %s expected %h seen %h", n, x, s);
		end
	endtask

	function automatic logic [33:0] pop(ref logic [33:0] q[$]);
		return q.size() != 0 ? q.pop_front() : 34'hX;
	endfunction

	function automatic int pend();
		return q_wr.size() + q_fe.size() + q_gp.size();
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		#1 d = reg_rdata;
	endtask

	// results as they leave the unit, against the model queues
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc > 20000)
		begin
			errors++;
			end_of_test();
		end
		if (mem_wr_valid)
			chk("push", {mem_wr.kind, mem_wr.data}, pop(q_wr));
		if (fetch_start)
		begin
			e = pop(q_fe);
			chk("fetch", {e[33], fetch_ivt, e[33] ? e[31:0] : fetch_addr}, e);
		end
		if (general_protection_fault)
		begin
			e = pop(q_gp);
			chk("fault", {e[33], 17'h0, e[33] ? e[15:0] : gp_code}, e);
		end
	end

	// one event in compatibility mode, with model of the chosen method
	task automatic run(input logic virtual_mode_ext_enable, input logic [1:0] pl, input logic rb,
		input logic [1:0] k, input logic [2:0] cd);
		logic [7:0]	v;
		logic	vf;
		logic [31:0]	fl, ef, mk, d;
		logic [15:0]	s[4], ec;
		v86_pkg::core_state_t	c;
		v86_pkg::desc_rsp_t	r;
		int	m, gf;
		v = 8'($urandom);
		// masked virtual interrupt case: virtual flag set, vector above the exceptions
		vf = virtual_mode_ext_enable && !rb && pl == 2'h1;
		v[5] = v[5] | vf;
		c = '{$urandom, 16'($urandom), $urandom, 16'($urandom), 16'($urandom)};
		r = '{v86_pkg::gate_kind_t'(k), cd[2], cd[1:0], 16'($urandom), $urandom, 32'h0000_0202};
		foreach (s[i])
			s[i] = 16'($urandom);
		fl = 32'h0002_4302 | {18'h0, pl, 12'h0};
		fl[19] = vf;
		m = (virtual_mode_ext_enable && !rb && !vf) ? 2 : ((pl == 2'h3 || vf) ? 0 : 1);
		core <= c;
		desc_rsp <= r;
		wr(v86_pkg::OFF_CTRL, {31'h0, virtual_mode_ext_enable});
		wr(v86_pkg::OFF_BITMAP + {3'h0, v[7:5], 2'h0}, {31'h0, rb} << v[4:0]);
		wr(v86_pkg::OFF_SEG_LO, {s[1], s[0]});
		wr(v86_pkg::OFF_SEG_HI, {s[3], s[2]});
		wr(v86_pkg::OFF_CPL, 32'h3);
		wr(v86_pkg::OFF_FLAGS, fl);
		ef = fl;
		mk = (m == 0 && k == 2'h0) ? 32'h0002_4300 : 32'h0002_0300;
		if (m == 1)
			q_gp.push_back(34'h0);
		else if (m == 2)
		begin
			q_wr.push_back({18'h1_0000, fl[15:0] & 16'h8FFF});
			q_wr.push_back({18'h1_0000, c.cs});
			q_wr.push_back({18'h1_0000, c.eip[15:0]});
			q_fe.push_back({2'h1, 22'h0, v, 2'h0});
			ef = fl & ~32'h0000_0300;
		end
		else if (k == 2'h0)
		begin
			q_wr.push_back({2'h2, fl});
			q_wr.push_back({18'h3_0000, c.tss_sel});
			q_fe.push_back({2'h0, r.entry});
			ef = 32'h0000_4202;
		end
		else if (k == 2'h3)
			q_gp.push_back({18'h0, 5'h00, v, 3'h2});
		else if (cd != 3'h0)
			q_gp.push_back({18'h0, r.code_sel});
		else
		begin
			for (int i = 3; i >= 0; i--)
				q_wr.push_back({18'h0, s[i]});
			q_wr.push_back({18'h0, c.ss});
			q_wr.push_back({2'h0, c.esp});
			q_wr.push_back({2'h0, fl | {18'h0, vf, vf, 12'h0}});
			q_wr.push_back({18'h0, c.cs});
			q_wr.push_back({2'h0, c.eip});
			q_fe.push_back({2'h0, r.entry});
			ef = fl & ~(k == 2'h2 ? 32'h0002_0300 : 32'h0002_0100);
			s = '{default: 16'h0};
		end
		gf = q_gp.size();
		ec = (gf != 0) ? q_gp[0][15:0] : 16'h0000;
		@(posedge sys_clk);
		evt_req <= 1'h1;
		evt_vec <= v;
		@(posedge sys_clk);
		evt_req <= 1'h0;
		for (int i = 0; i < 40 && (pend() != 0 || !evt_ready); i++)
			@(negedge sys_clk);
		chk("pending", 34'(pend()), 34'h0);
		chk("ready idle", {32'h0, evt_ready, desc_req}, 34'h2);
		if (m == 0)
			chk("table vector", {26'h0, desc_vec}, {26'h0, v});
		rd(v86_pkg::OFF_FLAGS, d);
		chk("flags", {2'h0, d & mk}, {2'h0, ef & mk});
		chk("mode", {33'h0, v86_active}, {33'h0, ef[17]});
		if (m != 0 || k != 2'h0)
		begin
			rd(v86_pkg::OFF_SEG_LO, d);
			chk("seg lo", {2'h0, d}, {2'h0, s[1], s[0]});
			rd(v86_pkg::OFF_SEG_HI, d);
			chk("seg hi", {2'h0, d}, {2'h0, s[3], s[2]});
		end
		if (gf != 0)
		begin
			rd(v86_pkg::OFF_ERR, d);
			chk("error code", {2'h0, d}, {18'h0, ec});
		end
		rd(v86_pkg::OFF_CPL, d);
		if (gf == 0)
			chk("level", {32'h0, d[1:0]}, m == 0 ? 34'h0 : 34'h3);
		$display("test %0d done", tn++);
	endtask

	// return from a handler with a given flags image
	task automatic ret(input logic [31:0] f, input logic vm);
		logic [31:0]	d;
		logic [3:0][15:0]	g;
		g = {$urandom, $urandom};
		@(posedge sys_clk);
		interrupt_return_instr_req <= 1'h1;
		interrupt_return_instr_flags <= f;
		interrupt_return_instr_segs <= g;
		@(posedge sys_clk);
		interrupt_return_instr_req <= 1'h0;
		@(negedge sys_clk);
		chk("return mode", {33'h0, v86_active}, {33'h0, vm});
		rd(v86_pkg::OFF_SEG_LO, d);
		chk("return seg", {2'h0, d}, {2'h0, g[1:0]});
		$display("test %0d done", tn++);
	endtask

	// virtual flag instructions
	task automatic pls(input logic en, input logic [31:0] x);
		logic [31:0]	d;
		@(posedge sys_clk);
		int_enable_instr <= en;
		int_disable_instr <= !en;
		@(posedge sys_clk);
		int_enable_instr <= 1'h0;
		int_disable_instr <= 1'h0;
		rd(v86_pkg::OFF_FLAGS, d);
		chk("virtual flag", {2'h0, d & 32'h001A_0200}, {2'h0, x});
	endtask

	// --------
	// main sequence
	// --------
	initial
	begin
		{sys_clk, reg_wr, reg_rd, evt_req, interrupt_return_instr_req} = 5'h0;
		{int_disable_instr, int_enable_instr, reg_addr, evt_vec, reg_wdata} = 50'h0;
		{core, desc_rsp, interrupt_return_instr_flags, interrupt_return_instr_segs} = '0;
		reset = 1'h1;
		clk_en = 1'h1;
		void'($urandom(32'h7910562A));
		repeat (16)
			@(posedge sys_clk);
		reset <= 1'h0;
		rd(v86_pkg::OFF_FLAGS, rv);
		chk("reset flags", {2'h0, rv}, {2'h0, v86_pkg::FLAGS_RESET});
		rd(8'hFC, rv);
		chk("unmapped", {2'h0, rv}, 34'h0);
		rd(v86_pkg::OFF_STATUS, rv);
		chk("status", {2'h0, rv}, 34'h0);
		run(1'h0, 2'h3, 1'h0, 2'h1, 3'h0);
		run(1'h0, 2'h3, 1'h0, 2'h2, 3'h0);
		run(1'h0, 2'h3, 1'h0, 2'h0, 3'h0);
		ret(32'h0002_0002, 1'h1);
		ret(32'h0000_0002, 1'h1);
		run(1'h0, 2'h3, 1'h0, 2'h1, 3'h4);
		run(1'h0, 2'h3, 1'h0, 2'h2, 3'h1);
		run(1'h0, 2'h3, 1'h0, 2'h3, 3'h0);
		run(1'h0, 2'($urandom_range(2)), 1'h0, 2'h1, 3'h0);
		run(1'h1, 2'($urandom_range(2)), 1'h1, 2'h1, 3'h0);
		run(1'h1, 2'h3, 1'h1, 2'h1, 3'h0);
		ret(32'h0002_0002, 1'h1);
		run(1'h1, 2'h3, 1'h0, 2'h1, 3'h0);
		run(1'h1, 2'h0, 1'h0, 2'h1, 3'h0);
		run(1'h1, 2'h1, 1'h0, 2'h1, 3'h0);
		wr(v86_pkg::OFF_CTRL, 32'h1);
		wr(v86_pkg::OFF_FLAGS, 32'h000A_0202);
		pls(1'h0, 32'h0002_0200);
		pls(1'h1, 32'h000A_0200);
		wr(v86_pkg::OFF_FLAGS, 32'h0012_0202);
		q_gp.push_back({2'h2, 32'h0});
		pls(1'h1, 32'h0012_0200);
		chk("pending", 34'(pend()), 34'h0);
		$display("test %0d done", tn++);
		end_of_test();
	end
endmodule
`default_nettype wire
